/* core/spg_top.sv */
// serial port configuration, idle clock stop and interval timer clock gate
// Contract
// R1: select clear: 3F8-3FF and IRQ4, else 2F8/IRQ3
// R2: stop uart clocks after programmed idle time
// R3: zero timeout disables, nonzero enables idle timer
// R4: scale clear one second, set eight seconds
// R5: unmasked activity restarts timer and clocks
// R6: falling modem/rx inputs retrigger unless masked
// R7: transmit buffer writes retrigger unless masked
// R8: counter clock stops in doze/sleep when set
// R9: power control fields reset to zero
// R10: port enable bit gates io decode
// R11: oscillator stop bit disables crystal oscillator
`default_nettype none
module spg_top #(
    parameter int TICK_CYCLES = spg_pkg::SPG_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spg_pkg::SPG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu io cycle
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic divisor_latch,
    // uart interrupt and serial pins
    input wire logic uart_irq,
    input wire logic rxd,
    input wire logic dcd_n,
    input wire logic ri_n,
    input wire logic dsr_n,
    input wire logic cts_n,
    // system power state
    input wire logic doze_sleep,
    // outputs
    output logic serial_port_cs,
    output logic irq3,
    output logic irq4,
    output logic uart_clk_en,
    output logic osc_en,
    output logic interval_timer_clk_en
);
    import spg_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic port_enable;
        logic osc_run;
        logic addr_select;
        logic input_mask;
        logic tx_mask;
        logic scale;
        logic [SPG_TMO_W-1:0] tmo;
        logic cnt_clk_stop;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [SPG_NUM_INPUTS-1:0] sync1;
        logic [SPG_NUM_INPUTS-1:0] sync2;
        logic [SPG_NUM_INPUTS-1:0] sync3;
        logic [SPG_NUM_INPUTS-1:0] level;
        logic [SPG_PRESC_W-1:0] presc;
        logic [SPG_SEC_W-1:0] secs;
        logic run;
        logic cs;
        logic irq3;
        logic irq4;
        logic timer_clk_en;
    } spg_state_t;

    spg_state_t state_ff;
    spg_state_t nxt_state;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] reg_index(input logic [SPG_ADDR_W-1:0] a);
        reg_index = 8'(a >> SPG_WORD_SHIFT);
    endfunction

    function automatic logic mapped(input logic [SPG_ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        mapped = (a[1:0] == 2'h0) && ((a >> SPG_WORD_SHIFT) == SPG_ADDR_W'(i)) &&
                 ((i == SPG_IDX_PORT_MODE) || (i == SPG_IDX_POWER_CTRL) || (i == SPG_IDX_TIMER_MODE));
    endfunction

    localparam logic [SPG_PRESC_W-1:0] PRESC_LAST = SPG_PRESC_W'(TICK_CYCLES - 1);

    logic [SPG_NUM_INPUTS-1:0] pins;
    logic [SPG_NUM_INPUTS-1:0] agree;
    logic [SPG_NUM_INPUTS-1:0] falls;
    logic access;
    logic [7:0] idx;
    logic [7:0] mode_rd;
    logic [7:0] pwr_rd;
    logic [7:0] tmr_rd;
    logic [9:0] base;
    logic io_hit;
    logic tx_write;
    logic retrigger;
    logic [SPG_SEC_W-1:0] limit;
    logic tick;
    logic first_cycle;
    logic wr_strobe;

    assign pins = {rxd, dcd_n, ri_n, dsr_n, cts_n};

    // ****************************************
    // input edge detection
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < SPG_NUM_INPUTS; g++)
        begin : g_edge
            assign agree[g] = state_ff.sync2[g] == state_ff.sync3[g];
            assign falls[g] = agree[g] && !state_ff.sync3[g] && state_ff.level[g]; // [R6]
        end
    endgenerate

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        access = psel && penable;
        idx = reg_index(paddr);
        mode_rd = 8'h00;
        mode_rd[SPG_POS_PORT_ENABLE] = state_ff.port_enable;
        mode_rd[SPG_POS_OSC_STOP] = !state_ff.osc_run;
        mode_rd[SPG_POS_ADDR_SELECT] = state_ff.addr_select;
        pwr_rd = 8'h00;
        pwr_rd[SPG_POS_INPUT_MASK] = state_ff.input_mask;
        pwr_rd[SPG_POS_TX_MASK] = state_ff.tx_mask;
        pwr_rd[SPG_POS_SCALE] = state_ff.scale;
        pwr_rd[SPG_POS_TMO_LSB +: SPG_TMO_W] = state_ff.tmo;
        tmr_rd = 8'h00;
        tmr_rd[SPG_POS_CNT_CLK_STOP] = state_ff.cnt_clk_stop;

        // ****************************************
        // apb: one wait cycle, then pready for one cycle
        // ****************************************
        first_cycle = access && !state_ff.ready;
        wr_strobe = access && state_ff.ready && pwrite && pstrb[0] && mapped(paddr);
        nxt_state.ready = first_cycle;
        nxt_state.err = first_cycle && !mapped(paddr);
        if (first_cycle)
        begin
            case (idx)
                SPG_IDX_PORT_MODE: nxt_state.rdata = {24'h000000, mode_rd};
                SPG_IDX_POWER_CTRL: nxt_state.rdata = {24'h000000, pwr_rd};
                SPG_IDX_TIMER_MODE: nxt_state.rdata = {24'h000000, tmr_rd};
                default: nxt_state.rdata = 32'h00000000;
            endcase
            if (!mapped(paddr) || pwrite)
            begin
                nxt_state.rdata = 32'h00000000;
            end
        end
        // ****************************************
        // register write
        // ****************************************
        if (wr_strobe)
        begin
            case (idx)
                SPG_IDX_PORT_MODE:
                begin
                    nxt_state.port_enable = pwdata[SPG_POS_PORT_ENABLE]; // [R10]
                    nxt_state.osc_run = !pwdata[SPG_POS_OSC_STOP]; // [R11]
                    nxt_state.addr_select = pwdata[SPG_POS_ADDR_SELECT]; // [R1]
                end
                SPG_IDX_POWER_CTRL:
                begin
                    nxt_state.input_mask = pwdata[SPG_POS_INPUT_MASK]; // [R6]
                    nxt_state.tx_mask = pwdata[SPG_POS_TX_MASK]; // [R7]
                    nxt_state.scale = pwdata[SPG_POS_SCALE]; // [R4]
                    nxt_state.tmo = pwdata[SPG_POS_TMO_LSB +: SPG_TMO_W]; // [R3]
                end
                SPG_IDX_TIMER_MODE:
                begin
                    nxt_state.cnt_clk_stop = pwdata[SPG_POS_CNT_CLK_STOP]; // [R8]
                end
                default:
                begin
                end
            endcase
        end

        // ****************************************
        // io window decode and interrupt routing
        // ****************************************
        base = state_ff.addr_select ? SPG_BASE_SECONDARY : SPG_BASE_PRIMARY; // [R1]
        io_hit = state_ff.port_enable && (io_addr[9:SPG_WIN_LSB] == base[9:SPG_WIN_LSB]); // [R10]
        nxt_state.cs = io_hit && (io_wr || io_rd);
        nxt_state.irq4 = state_ff.port_enable && !state_ff.addr_select && uart_irq; // [R1]
        nxt_state.irq3 = state_ff.port_enable && state_ff.addr_select && uart_irq; // [R1]
        tx_write = io_hit && io_wr && !divisor_latch && (io_addr[SPG_WIN_LSB-1:0] == SPG_TX_BUF_OFS);

        // ****************************************
        // pin synchronisers
        // ****************************************
        nxt_state.sync1 = pins;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;
        for (int i = 0; i < SPG_NUM_INPUTS; i++)
        begin
            if (agree[i])
            begin
                nxt_state.level[i] = state_ff.sync3[i];
            end
        end

        // ****************************************
        // activity timer
        // ****************************************
        retrigger = (!state_ff.input_mask && (falls != '0)) || // [R6]
                    (!state_ff.tx_mask && tx_write); // [R7]
        limit = state_ff.scale ? SPG_SEC_W'(state_ff.tmo * SPG_LONG_SCALE) : SPG_SEC_W'(state_ff.tmo); // [R4]
        tick = state_ff.presc == PRESC_LAST;
        if (state_ff.tmo == '0)
        begin
            nxt_state.presc = '0; // [R3]
            nxt_state.secs = '0;
            nxt_state.run = 1'b1;
        end
        else if (retrigger)
        begin
            nxt_state.presc = '0; // [R5]
            nxt_state.secs = '0;
            nxt_state.run = 1'b1;
        end
        else if (state_ff.run)
        begin
            nxt_state.presc = tick ? '0 : state_ff.presc + 1'b1;
            if (tick)
            begin
                nxt_state.secs = state_ff.secs + 1'b1;
                if (state_ff.secs + 1'b1 >= limit)
                begin
                    nxt_state.run = 1'b0; // [R2]
                end
            end
        end
        nxt_state.timer_clk_en = !(state_ff.cnt_clk_stop && doze_sleep); // [R8]
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff <= '0;
            state_ff.port_enable <= SPG_RST_PORT_MODE[SPG_POS_PORT_ENABLE];
            state_ff.osc_run <= !SPG_RST_PORT_MODE[SPG_POS_OSC_STOP];
            state_ff.addr_select <= SPG_RST_PORT_MODE[SPG_POS_ADDR_SELECT];
            state_ff.input_mask <= SPG_RST_POWER_CTRL[SPG_POS_INPUT_MASK]; // [R9]
            state_ff.tx_mask <= SPG_RST_POWER_CTRL[SPG_POS_TX_MASK];
            state_ff.scale <= SPG_RST_POWER_CTRL[SPG_POS_SCALE];
            state_ff.tmo <= SPG_RST_POWER_CTRL[SPG_POS_TMO_LSB +: SPG_TMO_W];
            state_ff.cnt_clk_stop <= SPG_RST_TIMER_MODE[SPG_POS_CNT_CLK_STOP];
            state_ff.sync1 <= '1;
            state_ff.sync2 <= '1;
            state_ff.sync3 <= '1;
            state_ff.level <= '1;
            state_ff.timer_clk_en <= 1'b1;
            state_ff.run <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = state_ff.rdata;
    assign pready = state_ff.ready;
    assign pslverr = state_ff.err;
    assign serial_port_cs = state_ff.cs;
    assign irq3 = state_ff.irq3;
    assign irq4 = state_ff.irq4;
    assign uart_clk_en = state_ff.run; // [R2]
    assign osc_en = state_ff.osc_run; // [R11]
    assign interval_timer_clk_en = state_ff.timer_clk_en;
endmodule
`default_nettype wire

/* core/spg_pkg.sv */
// package: register map, fields, resets and timing for serial port idle clock gating
`default_nettype none
package spg_pkg;
    // ****************************************
    // register indices and bus layout
    // ****************************************
    localparam logic [7:0] SPG_IDX_PORT_MODE = 8'h10;
    localparam logic [7:0] SPG_IDX_POWER_CTRL = 8'h11;
    localparam logic [7:0] SPG_IDX_TIMER_MODE = 8'h13;
    localparam int SPG_ADDR_W = 12;
    localparam int SPG_WORD_SHIFT = 2;
    // ****************************************
    // field positions
    // ****************************************
    localparam int SPG_POS_PORT_ENABLE = 7;
    localparam int SPG_POS_OSC_STOP = 6;
    localparam int SPG_POS_ADDR_SELECT = 5;
    localparam int SPG_POS_INPUT_MASK = 7;
    localparam int SPG_POS_TX_MASK = 6;
    localparam int SPG_POS_SCALE = 4;
    localparam int SPG_POS_TMO_LSB = 0;
    localparam int SPG_TMO_W = 4;
    localparam int SPG_POS_CNT_CLK_STOP = 0;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] SPG_RST_PORT_MODE = 8'h80;
    localparam logic [7:0] SPG_RST_POWER_CTRL = 8'h00;
    localparam logic [7:0] SPG_RST_TIMER_MODE = 8'h00;
    // ****************************************
    // serial port io windows and transmit buffer offset
    // ****************************************
    localparam logic [9:0] SPG_BASE_PRIMARY = 10'h3F8;
    localparam logic [9:0] SPG_BASE_SECONDARY = 10'h2F8;
    localparam int SPG_WIN_LSB = 3;
    localparam logic [2:0] SPG_TX_BUF_OFS = 3'h0;
    // ****************************************
    // timing
    // ****************************************
    localparam int SPG_CLK_HZ = 25000000;
    localparam int SPG_TICK_S = 1;
    localparam int SPG_TICK_CYCLES = SPG_TICK_S * SPG_CLK_HZ;
    localparam int SPG_LONG_SCALE = 8;
    localparam int SPG_PRESC_W = 25;
    localparam int SPG_SEC_W = 7;
    localparam int SPG_NUM_INPUTS = 5;
endpackage
`default_nettype wire

/* dv/spg_chk.sv */
// assertion checker for serial port idle clock gating
`default_nettype none
module spg_chk #(
    parameter int TICK_CYCLES = spg_pkg::SPG_TICK_CYCLES
) (
    // clock, reset and bus
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [spg_pkg::SPG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    // io cycle, pins and outputs
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic divisor_latch,
    input wire logic uart_irq,
    input wire logic rxd,
    input wire logic doze_sleep,
    input wire logic serial_port_cs,
    input wire logic irq3,
    input wire logic irq4,
    input wire logic uart_clk_en,
    input wire logic osc_en,
    input wire logic interval_timer_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import spg_pkg::*;
    // ****************************************
    // register shadow and checks
    // ****************************************
    localparam logic [11:0] A_MODE = {2'h0, SPG_IDX_PORT_MODE, 2'h0};
    localparam logic [11:0] A_PWR = {2'h0, SPG_IDX_POWER_CTRL, 2'h0};
    localparam logic [11:0] A_TMR = {2'h0, SPG_IDX_TIMER_MODE, 2'h0};
    logic [7:0] mode_ff;
    logic [7:0] pwr_ff;
    logic [7:0] tmr_ff;
    logic hit;
    logic tstop;
    logic [1:0] irq_exp;
    assign hit = (io_rd || io_wr) && mode_ff[7] && io_addr[9:3] == (mode_ff[5] ? 7'h5F : 7'h7F);
    assign tstop = tmr_ff[0] && doze_sleep;
    assign irq_exp = {mode_ff[7] && mode_ff[5] && uart_irq, mode_ff[7] && !mode_ff[5] && uart_irq};
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode_ff <= SPG_RST_PORT_MODE;
            pwr_ff <= SPG_RST_POWER_CTRL;
            tmr_ff <= SPG_RST_TIMER_MODE;
        end
        else if (psel && penable && pready && pwrite && pstrb[0])
        begin
            if (paddr == A_MODE)
                mode_ff <= pwdata[7:0];
            if (paddr == A_PWR)
                pwr_ff <= pwdata[7:0];
            if (paddr == A_TMR)
                tmr_ff <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_cs; serial_port_cs == $past(hit); endproperty
    a_cs: assert property (p_cs) else $error("chip select differs from decode");
    property p_irq; {irq3, irq4} == $past(irq_exp); endproperty
    a_irq: assert property (p_irq) else $error("interrupt routing wrong");
    property p_zero; pwr_ff[3:0] == 4'h0 |=> uart_clk_en; endproperty
    a_zero: assert property (p_zero) else $error("clock stopped with zero timeout");
    property p_stop; $fell(uart_clk_en) |-> ($past(pwr_ff) & 8'h0F) != 8'h00; endproperty
    a_stop: assert property (p_stop) else $error("clock stopped while timer off");
    property p_tx; io_wr && hit && io_addr[2:0] == 3'h0 && !divisor_latch && !pwr_ff[6] |=> uart_clk_en; endproperty
    a_tx: assert property (p_tx) else $error("transmit write did not wake clock");
    property p_pin; $fell(rxd) && !pwr_ff[7] |-> ##[1:6] uart_clk_en; endproperty
    a_pin: assert property (p_pin) else $error("pin fall did not wake clock");
    property p_osc; $stable(mode_ff) |-> osc_en == !mode_ff[6]; endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_interval_timer_clock; interval_timer_clk_en == !$past(tstop); endproperty
    a_interval_timer_clock: assert property (p_interval_timer_clock) else $error("interval timer clock gate wrong");
    c_stop: cover property ($fell(uart_clk_en));
    c_alt: cover property (serial_port_cs && mode_ff[5]);
    c_interval_timer_clock: cover property (!interval_timer_clk_en);
endmodule
bind spg_top spg_chk #(.TICK_CYCLES(TICK_CYCLES)) spg_chk_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .io_addr, .io_wr, .io_rd, .divisor_latch, .uart_irq, .rxd, .doze_sleep,
    .serial_port_cs, .irq3, .irq4, .uart_clk_en, .osc_en, .interval_timer_clk_en);
`default_nettype wire

/* dv/spg_tb_top.sv */
// testbench for serial port idle clock gating
`default_nettype none
module spg_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spg_pkg::*;
    // ****************************************
    // stimulus and scenarios
    // ****************************************
    localparam int T = 10;
    localparam logic [11:0] A_MODE = {2'h0, SPG_IDX_PORT_MODE, 2'h0};
    localparam logic [11:0] A_PWR = {2'h0, SPG_IDX_POWER_CTRL, 2'h0};
    localparam logic [11:0] A_TMR = {2'h0, SPG_IDX_TIMER_MODE, 2'h0};
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [9:0] io_addr = 10'h000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic divisor_latch = 1'b0;
    logic uart_irq = 1'b0;
    logic [4:0] pins = 5'h1F;
    logic doze_sleep = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_port_cs, irq3, irq4, uart_clk_en, osc_en, interval_timer_clk_en;
    int error_cnt = 0;
    int checked = 0;
    always #20 clk = ~clk;
    spg_top #(.TICK_CYCLES(T)) dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .io_addr, .io_wr, .io_rd, .divisor_latch, .uart_irq, .rxd(pins[4]),
        .dcd_n(pins[3]), .ri_n(pins[2]), .dsr_n(pins[1]), .cts_n(pins[0]), .doze_sleep, .serial_port_cs,
        .irq3, .irq4, .uart_clk_en, .osc_en, .interval_timer_clk_en);
    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e, input logic er);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, 32'(pready));
        if (n >= 20)
            final_report();
        chk("prdata", {24'h0, e}, prdata);
        chk("pslverr", 32'(er), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic io_cs(input logic [9:0] a, input logic rd, input logic exp);
        io_addr <= a;
        io_rd <= rd;
        io_wr <= !rd;
        @(posedge clk);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        @(posedge clk);
        chk("serial_port_cs", 32'(exp), 32'(serial_port_cs));
    endtask
    task automatic wait_en(input logic v, input int lim, output int n);
        n = 0;
        while (uart_clk_en !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk("uart_clk_en", 32'(v), 32'(uart_clk_en));
        if (n >= lim)
            final_report();
    endtask
    task automatic hold(input logic v, input int c);
        repeat (c)
        begin
            @(posedge clk);
            chk("uart_clk_en", 32'(v), 32'(uart_clk_en));
        end
    endtask
    task automatic t_regs();
        acc(1'b0, A_MODE, 8'h00, 8'h80, 1'b0);
        acc(1'b0, A_PWR, 8'h00, 8'h00, 1'b0);
        acc(1'b0, A_TMR, 8'h00, 8'h00, 1'b0);
        acc(1'b0, 12'h048, 8'h00, 8'h00, 1'b1);
        acc(1'b1, 12'h048, 8'hFF, 8'h00, 1'b1);
        acc(1'b0, 12'h440, 8'h00, 8'h00, 1'b1);
        pstrb <= 4'hE;
        acc(1'b1, A_TMR, 8'h01, 8'h00, 1'b0);
        pstrb <= 4'hF;
        acc(1'b0, A_TMR, 8'h00, 8'h00, 1'b0);
        chk("osc_en", 32'h1, 32'(osc_en));
    endtask
    task automatic t_decode();
        uart_irq <= 1'b1;
        io_cs(10'h3FF, 1'b1, 1'b1);
        chk("irq4", 32'h1, 32'(irq4));
        io_cs(10'h2F8, 1'b1, 1'b0);
        acc(1'b1, A_MODE, 8'hA0, 8'h00, 1'b0);
        io_cs(10'h2FF, 1'b0, 1'b1);
        chk("irq3", 32'h1, 32'(irq3));
        io_cs(10'h3F8, 1'b1, 1'b0);
        acc(1'b1, A_MODE, 8'h20, 8'h00, 1'b0);
        io_cs(10'h2F8, 1'b1, 1'b0);
        chk("irq3", 32'h0, 32'(irq3));
        acc(1'b1, A_MODE, 8'h80, 8'h00, 1'b0);
        uart_irq <= 1'b0;
    endtask
    task automatic t_idle(input logic [7:0] pw, input int lim);
        int n;
        acc(1'b1, A_PWR, pw, 8'h00, 1'b0);
        acc(1'b0, A_PWR, 8'h00, pw, 1'b0);
        io_cs(10'h3F8, 1'b0, 1'b1);
        wait_en(1'b0, lim + 2 * T, n);
        checked++;
        if (n < lim - T - 4 || n > lim + 4)
        begin
            error_cnt++;
            $display("BAD idle_cycles expected %0d seen %0d", lim, n);
        end
    endtask
    task automatic t_retrig();
        int n;
        acc(1'b1, A_PWR, 8'h01, 8'h00, 1'b0);
        wait_en(1'b0, 4 * T, n);
        io_cs(10'h3F8, 1'b0, 1'b1);
        chk("uart_clk_en", 32'h1, 32'(uart_clk_en));
        wait_en(1'b0, 4 * T, n);
        divisor_latch <= 1'b1;
        io_cs(10'h3F8, 1'b0, 1'b1);
        divisor_latch <= 1'b0;
        hold(1'b0, 3);
        acc(1'b1, A_PWR, 8'h41, 8'h00, 1'b0);
        io_cs(10'h3F8, 1'b0, 1'b1);
        hold(1'b0, 3);
        for (int i = 0; i < 5; i++)
        begin
            pins[i] <= 1'b0;
            wait_en(1'b1, 8, n);
            pins[i] <= 1'b1;
            wait_en(1'b0, 4 * T, n);
        end
        acc(1'b1, A_PWR, 8'h81, 8'h00, 1'b0);
        pins[4] <= 1'b0;
        hold(1'b0, 8);
        pins[4] <= 1'b1;
        io_cs(10'h3F8, 1'b0, 1'b1);
        chk("uart_clk_en", 32'h1, 32'(uart_clk_en));
        acc(1'b1, A_PWR, 8'h00, 8'h00, 1'b0);
        hold(1'b1, 3 * T);
    endtask
    task automatic t_gate();
        acc(1'b1, A_MODE, 8'hC0, 8'h00, 1'b0);
        @(posedge clk);
        chk("osc_en", 32'h0, 32'(osc_en));
        acc(1'b1, A_MODE, 8'h80, 8'h00, 1'b0);
        @(posedge clk);
        chk("osc_en", 32'h1, 32'(osc_en));
        doze_sleep <= 1'b1;
        acc(1'b1, A_TMR, 8'h01, 8'h00, 1'b0);
        @(posedge clk);
        chk("interval_timer_clock_en", 32'h0, 32'(interval_timer_clk_en));
        acc(1'b1, A_TMR, 8'h00, 8'h00, 1'b0);
        @(posedge clk);
        chk("interval_timer_clock_en", 32'h1, 32'(interval_timer_clk_en));
        doze_sleep <= 1'b0;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_decode();
        t_idle(8'h01, T);
        t_idle(8'h0F, 15 * T);
        t_idle(8'h11, 8 * T);
        t_idle(8'h1F, 120 * T);
        t_retrig();
        t_gate();
        final_report();
    end
endmodule
`default_nettype wire
